// File: core/rop_map.vh
// Opcode patterns, field positions and reset values for the return/option decoder
`ifndef ROP_MAP_VH
`define ROP_MAP_VH
`define ROP_OP_RET_IRQ    14'h0009
`define ROP_OP_LOAD_OPT   14'h0062
`define ROP_RETLIT_MASK   14'h3c00
`define ROP_RETLIT_PAT    14'h3400
`define ROP_LIT_HI        7
`define ROP_LIT_LO        0
`define ROP_OPT_RESET     8'hff
`define ROP_W_RESET       8'h00
`define ROP_PC_RESET      13'h0000
`define ROP_IRQ_EN_RESET  1'b0
`define ROP_SP_RESET      3'h0
`define ROP_STACK_RESET   13'h0000
`define ROP_RDATA_IDLE    8'h00
`define ROP_STATUS_RESET  3'h0
`define ROP_OPT_ADDR      7'h01
`define ROP_STACK_DEPTH   8
`define ROP_FLUSH_CYCLES  2'h1
`endif

// File: core/rop_core.v
// Decoder and executor for interrupt return, option load and literal return
`include "rop_map.vh"
module rop_core (
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire        instr_valid,
    input  wire [13:0] instr_word,
    input  wire        push_valid,
    input  wire [12:0] push_addr,
    input  wire [12:0] pc_seq,
    input  wire        file_wr,
    input  wire        file_rd,
    input  wire [6:0]  file_addr,
    input  wire [7:0]  file_wdata,
    input  wire        w_wr,
    input  wire [7:0]  w_wdata,
    input  wire        irq_take,
    input  wire [2:0]  status_in,
    output reg  [12:0] pc_out,
    output reg  [7:0]  w_out,
    output reg  [7:0]  option_out,
    output reg  [7:0]  file_rdata,
    output reg         global_irq_enable,
    output reg         discard_fetch,
    output reg  [2:0]  status_out
);

// -------------------------------------------------------------
// Decode helpers
// -------------------------------------------------------------
function is_ret_lit;
    input [13:0] iw;
    begin
        is_ret_lit = ((iw & `ROP_RETLIT_MASK) == `ROP_RETLIT_PAT);
    end
endfunction

function is_opt_addr;
    input [6:0] addr;
    begin
        is_opt_addr = (addr == `ROP_OPT_ADDR);
    end
endfunction

// Wrap-around step of the stack pointer, shared by push and pop
function [2:0] ptr_step;
    input [2:0] ptr;
    input       up;
    begin
        if (up) begin
            ptr_step = ptr + 3'h1;
        end else begin
            ptr_step = ptr - 3'h1;
        end
    end
endfunction

// -------------------------------------------------------------
// Instruction decode
// -------------------------------------------------------------
localparam [0:0] ST_EXEC  = 1'b0;
localparam [0:0] ST_FLUSH = 1'b1;

reg  [0:0]  state_reg;
wire        in_flush                 = (state_reg == ST_FLUSH);
// Word fetched behind a return is dropped, never executed
wire        exec_ok                  = instr_valid & ~in_flush;
wire        return_from_interrupt_op = exec_ok & (instr_word == `ROP_OP_RET_IRQ);
wire        load_option_op           = exec_ok & (instr_word == `ROP_OP_LOAD_OPT);
wire        return_with_literal_op   = exec_ok & is_ret_lit(instr_word);
wire [7:0]  literal_val              = instr_word[`ROP_LIT_HI:`ROP_LIT_LO];
wire        pop_op                   = return_from_interrupt_op | return_with_literal_op;
wire        opt_write                = file_wr & is_opt_addr(file_addr);
wire        opt_read                 = file_rd & is_opt_addr(file_addr);

// -------------------------------------------------------------
// Return stack
// -------------------------------------------------------------
reg  [12:0] stack_mem [0:`ROP_STACK_DEPTH-1];
reg  [2:0]  sp_reg;
reg  [2:0]  sp_next;
reg         push_ok;
wire [2:0]  sp_top          = ptr_step(sp_reg, 1'b0);
wire [2:0]  sp_up           = ptr_step(sp_reg, 1'b1);
wire [12:0] stack_top_entry = stack_mem[sp_top];
integer     i;

// Pop wins over a push in the same cycle; the push is dropped
always @* begin
    sp_next = sp_reg;
    push_ok = 1'b0;
    if (pop_op) begin
        sp_next = sp_top;
    end else if (push_valid) begin
        sp_next = sp_up;
        push_ok = 1'b1;
    end
end

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        sp_reg <= `ROP_SP_RESET;
        for (i = 0; i < `ROP_STACK_DEPTH; i = i + 1) begin
            stack_mem[i] <= `ROP_STACK_RESET;
        end
    end else begin
        sp_reg <= sp_next;
        if (push_ok) begin
            stack_mem[sp_reg] <= push_addr;
        end
    end
end

// -------------------------------------------------------------
// Two-cycle return sequencing
// -------------------------------------------------------------
reg [0:0] state_next;
reg [1:0] flush_cnt_reg;
reg [1:0] flush_cnt_next;

always @* begin
    state_next     = state_reg;
    flush_cnt_next = flush_cnt_reg;
    case (state_reg)
        ST_EXEC: begin
            if (pop_op) begin
                state_next     = ST_FLUSH;
                flush_cnt_next = `ROP_FLUSH_CYCLES;
            end
        end
        ST_FLUSH: begin
            if (flush_cnt_reg > 2'h1) begin
                flush_cnt_next = flush_cnt_reg - 2'h1;
            end else begin
                state_next     = ST_EXEC;
                flush_cnt_next = 2'h0;
            end
        end
        default: begin
            state_next     = ST_EXEC;
            flush_cnt_next = 2'h0;
        end
    endcase
end

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        state_reg     <= ST_EXEC;
        flush_cnt_reg <= 2'h0;
    end else begin
        state_reg     <= state_next;
        flush_cnt_reg <= flush_cnt_next;
    end
end

// -------------------------------------------------------------
// Next values of the visible registers
// -------------------------------------------------------------
reg [12:0] pc_next;
reg        discard_next;
reg        irq_en_next;
reg [7:0]  w_next;
reg [7:0]  option_next;
reg [7:0]  rdata_next;
reg [2:0]  status_next;

// Program counter follows the core unless a return redirects it
always @* begin
    pc_next      = pc_seq;
    discard_next = 1'b0;
    if (pop_op) begin
        pc_next      = stack_top_entry;
        discard_next = 1'b1;
    end
end

// Set by interrupt return wins over a same-cycle clear
always @* begin
    irq_en_next = global_irq_enable;
    if (return_from_interrupt_op) begin
        irq_en_next = 1'b1;
    end else if (irq_take) begin
        irq_en_next = 1'b0;
    end
end

always @* begin
    w_next = w_out;
    if (return_with_literal_op) begin
        w_next = literal_val;
    end else if (w_wr) begin
        w_next = w_wdata;
    end
end

// Opcode load wins over a same-cycle file write
always @* begin
    option_next = option_out;
    if (load_option_op) begin
        option_next = w_out;
    end else if (opt_write) begin
        option_next = file_wdata;
    end
end

always @* begin
    rdata_next = `ROP_RDATA_IDLE;
    if (opt_read) begin
        rdata_next = option_out;
    end
end

// Flags of other instructions pass through untouched
always @* begin
    status_next = status_in;
end

// -------------------------------------------------------------
// Output registers
// -------------------------------------------------------------
always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        pc_out            <= `ROP_PC_RESET;
        w_out             <= `ROP_W_RESET;
        option_out        <= `ROP_OPT_RESET;
        file_rdata        <= `ROP_RDATA_IDLE;
        global_irq_enable <= `ROP_IRQ_EN_RESET;
        discard_fetch     <= 1'b0;
        status_out        <= `ROP_STATUS_RESET;
    end else begin
        pc_out            <= pc_next;
        w_out             <= w_next;
        option_out        <= option_next;
        file_rdata        <= rdata_next;
        global_irq_enable <= irq_en_next;
        discard_fetch     <= discard_next;
        status_out        <= status_next;
    end
end

endmodule

// File: testbench/rop_checker.sv
// Port checker for the return and option decoder
module rop_checker (
    input logic        ref_clk,
    input logic        reset_n,
    input logic        instr_valid,
    input logic        file_rd,
    input logic        file_wr,
    input logic        discard_fetch,
    input logic        global_irq_enable,
    input logic [13:0] instr_word,
    input logic [12:0] pc_seq,
    input logic [12:0] pc_out,
    input logic [7:0]  w_out,
    input logic [7:0]  option_out,
    input logic [7:0]  file_rdata,
    input logic [6:0]  file_addr,
    input logic [2:0]  status_in,
    input logic [2:0]  status_out
);
    // Instruction taken only outside the flush cycle
    wire       take = instr_valid && !discard_fetch;
    wire       rfi  = take && instr_word == 14'h0009;
    wire       rlw  = take && instr_word[13:10] == 4'hd;
    wire       opt  = take && instr_word == 14'h0062;
    wire       pop  = rfi || rlw;
    wire [7:0] lit  = instr_word[7:0];
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_irq_en; rfi |=> global_irq_enable; endproperty
    a_irq_en: assert property (p_irq_en) else $error("enable flag not set");
    property p_lit; rlw |=> w_out == $past(lit); endproperty
    a_lit: assert property (p_lit) else $error("literal not loaded");
    property p_opt; opt |=> option_out == $past(w_out); endproperty
    a_opt: assert property (p_opt) else $error("option not loaded");
    property p_flush; pop |=> discard_fetch ##1 !discard_fetch; endproperty
    a_flush: assert property (p_flush) else $error("flush pulse wrong");
    property p_cause; discard_fetch |-> $past(pop); endproperty
    a_cause: assert property (p_cause) else $error("flush without return");
    property p_stat; $past(reset_n) |-> status_out == $past(status_in); endproperty
    a_stat: assert property (p_stat) else $error("status altered");
    property p_rd; file_rd && !file_wr && file_addr == 7'h01 && !opt |=> file_rdata == $past(option_out); endproperty
    a_rd: assert property (p_rd) else $error("option read wrong");
    property p_seq; !discard_fetch && !rfi && !rlw |=> pc_out == $past(pc_seq); endproperty
    a_seq: assert property (p_seq) else $error("pc not sequential");
    c_rfi: cover property (rfi);
    c_rlw: cover property (rlw);
    c_opt: cover property (opt);
endmodule
bind rop_core rop_checker rop_checker_inst (
    .ref_clk           (ref_clk),
    .reset_n           (reset_n),
    .instr_valid       (instr_valid),
    .file_rd           (file_rd),
    .file_wr           (file_wr),
    .discard_fetch     (discard_fetch),
    .global_irq_enable (global_irq_enable),
    .instr_word        (instr_word),
    .pc_seq            (pc_seq),
    .pc_out            (pc_out),
    .w_out             (w_out),
    .option_out        (option_out),
    .file_rdata        (file_rdata),
    .file_addr         (file_addr),
    .status_in         (status_in),
    .status_out        (status_out)
);

// File: testbench/return_and_option_ops_bench.sv
// Self-checking bench for the return and option decoder
module return_and_option_ops_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk = 0, reset_n = 0, instr_valid = 0, push_valid = 0, file_wr = 0, file_rd = 0, w_wr = 0;
    logic        irq_take = 0;
    logic [13:0] instr_word = 0, rw;
    logic [12:0] push_addr = 0, pc_seq = 0, a, b;
    logic [7:0]  file_wdata = 0, w_wdata = 0, k;
    logic [6:0]  file_addr = 7'h01;
    logic [2:0]  status_in = 0;
    wire  [12:0] pc_out;
    wire  [7:0]  w_out, option_out, file_rdata;
    wire         global_irq_enable, discard_fetch;
    wire  [2:0]  status_out;
    integer      err_count = 0, comparisons = 0, seed = 32'he6d6386c, i;
    always #5 ref_clk = ~ref_clk;
    rop_core rop_core_inst (
        .ref_clk           (ref_clk),
        .reset_n           (reset_n),
        .instr_valid       (instr_valid),
        .instr_word        (instr_word),
        .push_valid        (push_valid),
        .push_addr         (push_addr),
        .pc_seq            (pc_seq),
        .file_wr           (file_wr),
        .file_rd           (file_rd),
        .file_addr         (file_addr),
        .file_wdata        (file_wdata),
        .w_wr              (w_wr),
        .w_wdata           (w_wdata),
        .irq_take          (irq_take),
        .status_in         (status_in),
        .pc_out            (pc_out),
        .w_out             (w_out),
        .option_out        (option_out),
        .file_rdata        (file_rdata),
        .global_irq_enable (global_irq_enable),
        .discard_fetch     (discard_fetch),
        .status_out        (status_out)
    );
    // Literal carried by a literal-return word
    function automatic logic [7:0] lit_of(input logic [13:0] iw);
        lit_of = iw[7:0];
    endfunction
    task chk(input string n, input logic [15:0] e, g);
        comparisons++;
        if (e !== g) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task cyc(input logic [13:0] iw, input logic v, pv, input logic [12:0] pa);
        @(negedge ref_clk);
        instr_word = iw;
        instr_valid = v;
        push_valid = pv;
        push_addr = pa;
        pc_seq = 13'($random(seed));
        status_in = 3'($random(seed));
    endtask
    task tally_and_finish;
        if (err_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge ref_clk);
        @(negedge ref_clk) reset_n = 1;
        for (i = 0; i < 40; i++) begin
            a = 13'($random(seed));
            b = 13'($random(seed));
            k = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            cyc(14'h0000, 0, 1, a);
            irq_take = 1;
            cyc(14'h0000, 0, 1, b);
            {irq_take, w_wr, w_wdata} = {2'b01, k};
            cyc(14'h0062, 1, 0, 0);
            w_wr = 0;
            cyc(14'h0009, 1, 0, 0);
            chk("option", k, option_out);
            cyc({4'hd, i[1:0], k}, 1, 0, 0);
            chk("pc", b, pc_out);
            chk("irq_enable", 1'b1, global_irq_enable);
            chk("discard", 1'b1, discard_fetch);
            rw = {4'hd, 2'(i >> 2), ~k};
            cyc(rw, 1, 0, 0);
            chk("w_kept", k, w_out);
            cyc(14'h0000, 0, 0, 0);
            {file_wr, file_wdata} = {1'b1, k ^ 8'h5a};
            chk("pc_ret", a, pc_out);
            chk("w_lit", lit_of(rw), w_out);
            cyc(14'h0000, 0, 0, 0);
            {file_wr, file_rd} = 2'b01;
            cyc(14'h0000, 0, 0, 0);
            file_rd = 0;
            chk("rdata", k ^ 8'h5a, file_rdata);
            cyc(14'h0000, 0, 0, 0);
        end
        tally_and_finish;
    end
    initial begin
        #20000;
        err_count++;
        tally_and_finish;
    end
endmodule
